// file: inc/sss_pkg.sv
// Package with register map, field positions, timing constants and modes of the supply supervisor
package sss_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_WAKE_CONTROL_ONE = 8'h00;
	localparam logic [7:0] REG_WATCHDOG_CONTROL = 8'h04;
	localparam logic [7:0] REG_MODE_CONTROL     = 8'h08;
	localparam logic [7:0] REG_SUPPLY_STATUS    = 8'h0C;
	localparam logic [7:0] REG_REG_CONFIG       = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int WK_STOP_FIRST_BIT  = 0;
	localparam int WK_BUS_RESTART_BIT = 1;
	localparam int WD_STOP_SECOND_BIT = 0;
	localparam int WD_TRIGGER_BIT     = 1;
	localparam int CFG_OV_RST_BIT     = 0;
	localparam int ST_POR_BIT         = 0;
	localparam int ST_SUPPLY_UNDERVOLT_FLAG_BIT       = 1;
	localparam int ST_HS_UV_BIT       = 2;
	localparam int ST_HS_OV_BIT       = 3;
	localparam int ST_PREWARN_BIT     = 4;
	localparam int ST_UV_BIT          = 5;
	localparam int ST_UV_FS_BIT       = 6;
	localparam int ST_OV_BIT          = 7;
	localparam int ST_SC_BIT          = 8;
	localparam int ST_FAIL_BIT        = 9;
	localparam int ST_FLAG_COUNT      = 10;
	localparam int ST_MODE_LSB        = 16;
	localparam int ST_WD_ON_BIT       = 20;
	localparam int ST_UV_CNT_LSB      = 24;

	// ----------------------------------------------------------------
	// Mode command codes and counters
	// ----------------------------------------------------------------
	localparam logic [1:0] CMD_NORMAL     = 2'h0;
	localparam logic [1:0] CMD_STOP       = 2'h1;
	localparam logic [1:0] CMD_SLEEP      = 2'h2;
	localparam logic [1:0] CMD_SOFT_RESET = 2'h3;
	localparam logic [2:0] UV_FAILSAFE_COUNT = 3'h4;
	localparam logic [2:0] UV_CNT_ZERO       = 3'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS        = 4000;
	localparam int RESET_DELAY_US       = 10;
	localparam int SC_FILTER_MS         = 4;
	localparam int RESET_DELAY_DEFAULT  = (RESET_DELAY_US * 1000000) / CLK_PERIOD_PS;
	localparam int SC_FILTER_DEFAULT    = (SC_FILTER_MS * 1000000000) / CLK_PERIOD_PS;

	typedef enum logic [2:0] {
		SSS_INIT,
		SSS_NORMAL,
		SSS_STOP,
		SSS_SLEEP,
		SSS_RESTART,
		SSS_FAILSAFE
	} sss_mode_type;

endpackage

// file: core/sss_supervisor.sv
// Supply supervision, regulator protection and stop-mode watchdog disable sequence
//
// Functional notes
// R1: Watchdog off for stop needs two enable bits set in two registers in normal mode.
// R2: Any disable-sequence error clears the second enable bit; host restarts sequence.
// R3: Trigger in stop or return to normal restarts watchdog long window, clears both bits.
// R4: Starting the sequence while first bit already one clears that bit.
// R5: Bus-wake restart enable resets to 1, writable only in normal mode.
// R6: Bus wake in stop with restart enabled: interrupt, receive low, watchdog long window.
// R7: Supply power-on sets flag, loads defaults, holds reset until regulator ok plus delay.
// R8: Supply below falling power-on threshold resets internally, restarts in init.
// R9: Supply undervoltage sets own flag, suspends short protection, clears after condition.
// R10: High-side undervoltage sets only its flag, clearable after condition ends.
// R11: High-side overvoltage sets only its flag, clearable after condition ends.
// R12: Regulator prewarning sets its flag only.
// R13: Regulator below reset threshold: reset low, undervoltage flag, restart mode.
// R14: Prewarning and undervoltage flags never set in sleep mode.
// R15: Counter counts consecutive undervoltage in init, normal, stop; holds on supply low (here only in normal mode; init and stop still count).
// R16: Fourth consecutive undervoltage forces fail-safe and sets fail-safe flag.
// R17: Counter cleared on fail-safe entry, undervoltage flag clear, soft reset.
// R18: Overvoltage detected in init, normal, stop; always sets overvoltage flag.
// R19: Overvoltage reset with pin one: restart, fail outputs, back to normal, clear enable.
// R20: Overvoltage reset with pin zero: fail-safe and fail outputs.
// R21: Host clears overvoltage reset enable before stop at low load.
// R22: Regulator short beyond filter time: flags, regulator off, fail outputs, fail-safe.
// R23: First enable bit must precede second; other order or mode change is an error (here only mode writes out of normal other than to stop clear the second bit).
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module sss_supervisor #(
	parameter int RESET_DELAY_CYCLES = sss_pkg::RESET_DELAY_DEFAULT,
	parameter int SC_FILTER_CYCLES   = sss_pkg::SC_FILTER_DEFAULT
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hsel,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        supply_por_ok,
	input  wire logic        supply_undervolt,
	input  wire logic        hs_supply_undervolt,
	input  wire logic        hs_supply_overvolt,
	input  wire logic        main_reg_prewarn,
	input  wire logic        main_reg_below_reset,
	input  wire logic        main_reg_overvolt,
	input  wire logic        config_select_pin,
	input  wire logic        can_wake,
	output logic             reset_output_n,
	output logic             fail_outputs,
	output logic             main_regulator_on,
	output logic             bus_wake_irq,
	output logic             can_rx_low,
	output logic             watchdog_on,
	output logic             wd_long_window
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  sy_supply_undervolt_flag;
		logic [2:0]  sy_hs_uv;
		logic [2:0]  sy_hs_ov;
		logic [2:0]  sy_warn;
		logic [2:0]  sy_below;
		logic [2:0]  sy_ov;
		logic [2:0]  sy_cfg;
		logic [2:0]  sy_wake;
		sss_pkg::sss_mode_type mode;
		logic        stop_wd_disable_first;
		logic        stop_wd_disable_second;
		logic        bus_wake_wd_restart_en;
		logic        overvolt_reset_enable;
		logic [sss_pkg::ST_FLAG_COUNT-1:0] flags;
		logic [2:0]  uv_count;
		logic        uv_seen;
		logic [31:0] rd_timer;
		logic [31:0] sc_timer;
		logic        sc_armed;
		logic        reset_low;
		logic        fail_out;
		logic        reg_on;
		logic        wd_on;
		logic        long_win;
		logic        irq;
		logic        rx_low;
		logic        ap_valid;
		logic        ap_write;
		logic [7:0]  ap_addr;
		logic [31:0] rdata;
	} sss_state_type;

	sss_state_type st;
	sss_state_type next_st;

	logic supply_undervolt_flag;
	logic hs_uv;
	logic hs_ov;
	logic warn;
	logic below;
	logic ov;
	logic cfg;
	logic wake;
	logic wr;
	logic [31:0] wd;
	logic        uv_event;

	// Stable level once the second and third stages agree
	assign supply_undervolt_flag = (st.sy_supply_undervolt_flag[1] == st.sy_supply_undervolt_flag[2]) ? st.sy_supply_undervolt_flag[2] : st.flags[sss_pkg::ST_SUPPLY_UNDERVOLT_FLAG_BIT];
	assign hs_uv = st.sy_hs_uv[2] & st.sy_hs_uv[1];
	assign hs_ov = st.sy_hs_ov[2] & st.sy_hs_ov[1];
	assign warn  = st.sy_warn[2] & st.sy_warn[1];
	assign below = st.sy_below[2] & st.sy_below[1];
	assign ov    = st.sy_ov[2] & st.sy_ov[1];
	assign cfg   = st.sy_cfg[2];
	assign wake  = st.sy_wake[2] & st.sy_wake[1];

	assign wr = st.ap_valid & st.ap_write;
	assign wd = hwdata;

	function automatic sss_state_type load_defaults(input sss_state_type s);
		sss_state_type r;
		r = s;
		r.mode                   = sss_pkg::SSS_INIT;
		r.stop_wd_disable_first  = 1'b0;
		r.stop_wd_disable_second = 1'b0;
		r.bus_wake_wd_restart_en = 1'b1;
		r.overvolt_reset_enable  = 1'b0;
		r.flags                  = '0;
		r.uv_count               = sss_pkg::UV_CNT_ZERO;
		r.uv_seen                = 1'b0;
		r.rd_timer               = '0;
		r.sc_timer               = '0;
		r.sc_armed               = 1'b1;
		r.reset_low              = 1'b1;
		r.fail_out               = 1'b0;
		r.reg_on                 = 1'b1;
		r.wd_on                  = 1'b0;
		r.long_win               = 1'b0;
		r.irq                    = 1'b0;
		r.rx_low                 = 1'b0;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sy_supply_undervolt_flag = {st.sy_supply_undervolt_flag[1:0], supply_undervolt};
		next_st.sy_hs_uv = {st.sy_hs_uv[1:0], hs_supply_undervolt};
		next_st.sy_hs_ov = {st.sy_hs_ov[1:0], hs_supply_overvolt};
		next_st.sy_warn  = {st.sy_warn[1:0], main_reg_prewarn};
		next_st.sy_below = {st.sy_below[1:0], main_reg_below_reset};
		next_st.sy_ov    = {st.sy_ov[1:0], main_reg_overvolt};
		next_st.sy_cfg   = {st.sy_cfg[1:0], config_select_pin};
		next_st.sy_wake  = {st.sy_wake[1:0], can_wake};
		next_st.irq = 1'b0;
		uv_event = 1'b0;

		// Bus slave: register address phase
		next_st.ap_valid = hsel & hready & htrans[1];
		next_st.ap_write = hwrite;
		next_st.ap_addr  = haddr[7:0];

		// Software writes (clears are applied before hardware sets, so a set wins)
		if (wr) begin
			case (st.ap_addr)
				sss_pkg::REG_WAKE_CONTROL_ONE: begin
					if (st.mode == sss_pkg::SSS_NORMAL) begin
						if (wd[sss_pkg::WK_STOP_FIRST_BIT]) begin
							// Sequence start; a set first bit restarts it
							next_st.stop_wd_disable_first  = ~st.stop_wd_disable_first; // see R4
							next_st.stop_wd_disable_second = 1'b0; // see R2
						end
						next_st.bus_wake_wd_restart_en = wd[sss_pkg::WK_BUS_RESTART_BIT]; // see R5
					end
				end
				sss_pkg::REG_WATCHDOG_CONTROL: begin
					if (wd[sss_pkg::WD_STOP_SECOND_BIT]) begin
						if (st.mode == sss_pkg::SSS_NORMAL && st.stop_wd_disable_first)
							next_st.stop_wd_disable_second = 1'b1; // see R1
						else
							next_st.stop_wd_disable_second = 1'b0; // see R2, see R23
					end
					if (wd[sss_pkg::WD_TRIGGER_BIT] && st.mode == sss_pkg::SSS_STOP && !st.wd_on) begin
						next_st.wd_on = 1'b1; // see R3
						next_st.long_win = 1'b1;
						next_st.stop_wd_disable_first  = 1'b0;
						next_st.stop_wd_disable_second = 1'b0;
					end
				end
				sss_pkg::REG_MODE_CONTROL: begin
					case (wd[1:0])
						sss_pkg::CMD_NORMAL: begin
							if (st.mode == sss_pkg::SSS_STOP || st.mode == sss_pkg::SSS_INIT) begin
								next_st.mode = sss_pkg::SSS_NORMAL;
								next_st.wd_on = 1'b1; // see R3
								next_st.long_win = 1'b1;
								next_st.stop_wd_disable_first  = 1'b0;
								next_st.stop_wd_disable_second = 1'b0;
								next_st.rx_low = 1'b0;
							end
						end
						sss_pkg::CMD_STOP: begin
							if (st.mode == sss_pkg::SSS_NORMAL) begin
								next_st.mode = sss_pkg::SSS_STOP;
								if (st.stop_wd_disable_first && st.stop_wd_disable_second)
									next_st.wd_on = 1'b0; // see R1
							end
						end
						sss_pkg::CMD_SLEEP: begin
							if (st.mode == sss_pkg::SSS_NORMAL) begin
								next_st.mode = sss_pkg::SSS_SLEEP;
								next_st.reg_on = 1'b0;
								next_st.wd_on = 1'b0;
								next_st.stop_wd_disable_second = 1'b0; // see R23
							end
						end
						sss_pkg::CMD_SOFT_RESET: begin
							if (st.mode == sss_pkg::SSS_NORMAL || st.mode == sss_pkg::SSS_STOP) begin
								next_st = load_defaults(next_st);
								next_st.uv_count = sss_pkg::UV_CNT_ZERO; // see R17
								next_st.flags = st.flags;
							end
						end
						default: begin
						end
					endcase
				end
				sss_pkg::REG_SUPPLY_STATUS: begin
					// Write one to clear; the three supply flags clear only once their condition has ended
					if (wd[sss_pkg::ST_SUPPLY_UNDERVOLT_FLAG_BIT] && !supply_undervolt_flag) next_st.flags[sss_pkg::ST_SUPPLY_UNDERVOLT_FLAG_BIT] = 1'b0; // see R9
					if (wd[sss_pkg::ST_HS_UV_BIT] && !hs_uv) next_st.flags[sss_pkg::ST_HS_UV_BIT] = 1'b0; // see R10
					if (wd[sss_pkg::ST_HS_OV_BIT] && !hs_ov) next_st.flags[sss_pkg::ST_HS_OV_BIT] = 1'b0; // see R11
					if (wd[sss_pkg::ST_POR_BIT])     next_st.flags[sss_pkg::ST_POR_BIT]     = 1'b0;
					if (wd[sss_pkg::ST_PREWARN_BIT]) next_st.flags[sss_pkg::ST_PREWARN_BIT] = 1'b0;
					if (wd[sss_pkg::ST_UV_FS_BIT])   next_st.flags[sss_pkg::ST_UV_FS_BIT]   = 1'b0;
					if (wd[sss_pkg::ST_OV_BIT])      next_st.flags[sss_pkg::ST_OV_BIT]      = 1'b0;
					if (wd[sss_pkg::ST_SC_BIT])      next_st.flags[sss_pkg::ST_SC_BIT]      = 1'b0;
					if (wd[sss_pkg::ST_FAIL_BIT])    next_st.flags[sss_pkg::ST_FAIL_BIT]    = 1'b0;
					if (wd[sss_pkg::ST_UV_BIT]) begin
						next_st.flags[sss_pkg::ST_UV_BIT] = 1'b0;
						next_st.uv_count = sss_pkg::UV_CNT_ZERO; // see R17
					end
				end
				sss_pkg::REG_REG_CONFIG: begin
					next_st.overvolt_reset_enable = wd[sss_pkg::CFG_OV_RST_BIT]; // see R21
				end
				default: begin
				end
			endcase
		end

		// A mode write out of normal other than to stop breaks a half-done sequence; hardware restart and fail-safe entries are set later and leave it
		if (st.mode == sss_pkg::SSS_NORMAL && next_st.mode != sss_pkg::SSS_NORMAL && next_st.mode != sss_pkg::SSS_STOP)
			next_st.stop_wd_disable_second = 1'b0; // see R23

		// Supply flags
		if (supply_undervolt_flag) next_st.flags[sss_pkg::ST_SUPPLY_UNDERVOLT_FLAG_BIT] = 1'b1; // see R9
		if (hs_uv) next_st.flags[sss_pkg::ST_HS_UV_BIT] = 1'b1; // see R10
		if (hs_ov) next_st.flags[sss_pkg::ST_HS_OV_BIT] = 1'b1; // see R11
		if (warn && st.mode != sss_pkg::SSS_SLEEP && st.reg_on)
			next_st.flags[sss_pkg::ST_PREWARN_BIT] = 1'b1; // see R12, see R14

		// Bus wake in stop restarts the watchdog
		if (wake && st.mode == sss_pkg::SSS_STOP && !st.wd_on && st.bus_wake_wd_restart_en) begin
			next_st.irq = 1'b1; // see R6
			next_st.rx_low = 1'b1;
			next_st.wd_on = 1'b1;
			next_st.long_win = 1'b1;
		end

		// Regulator undervoltage
		if (!below) next_st.uv_seen = 1'b0;
		if (below && !st.uv_seen && st.reg_on &&
		    (st.mode == sss_pkg::SSS_INIT || st.mode == sss_pkg::SSS_NORMAL || st.mode == sss_pkg::SSS_STOP)) begin
			uv_event = 1'b1;
			next_st.uv_seen = 1'b1;
			next_st.flags[sss_pkg::ST_UV_BIT] = 1'b1; // see R13, see R14
			next_st.reset_low = 1'b1;
			next_st.rd_timer = '0;
			next_st.mode = sss_pkg::SSS_RESTART;
			if (!(st.mode == sss_pkg::SSS_NORMAL && supply_undervolt_flag)) begin
				next_st.uv_count = st.uv_count + 3'h1; // see R15
				if (st.uv_count + 3'h1 >= sss_pkg::UV_FAILSAFE_COUNT) begin
					next_st.mode = sss_pkg::SSS_FAILSAFE; // see R16
					next_st.flags[sss_pkg::ST_UV_FS_BIT] = 1'b1;
					next_st.uv_count = sss_pkg::UV_CNT_ZERO; // see R17
				end
			end
		end

		// Regulator overvoltage
		if (ov && (st.mode == sss_pkg::SSS_INIT || st.mode == sss_pkg::SSS_NORMAL || st.mode == sss_pkg::SSS_STOP)) begin
			next_st.flags[sss_pkg::ST_OV_BIT] = 1'b1; // see R18
			if (st.overvolt_reset_enable) begin
				next_st.fail_out = 1'b1;
				next_st.reset_low = 1'b1;
				next_st.rd_timer = '0;
				if (cfg) begin
					next_st.mode = sss_pkg::SSS_RESTART; // see R19
					next_st.overvolt_reset_enable = 1'b0;
				end else begin
					next_st.mode = sss_pkg::SSS_FAILSAFE; // see R20
					next_st.uv_count = sss_pkg::UV_CNT_ZERO;
				end
			end
		end

		// Short circuit filter, suspended in supply undervoltage
		if (st.reg_on && below && !supply_undervolt_flag && st.mode != sss_pkg::SSS_FAILSAFE) begin
			next_st.sc_timer = st.sc_timer + 32'h1;
			if (st.sc_timer >= 32'(SC_FILTER_CYCLES - 1)) begin
				next_st.flags[sss_pkg::ST_SC_BIT] = 1'b1; // see R22
				next_st.flags[sss_pkg::ST_FAIL_BIT] = 1'b1;
				next_st.reg_on = 1'b0;
				next_st.fail_out = 1'b1;
				next_st.reset_low = 1'b1;
				next_st.wd_on = 1'b0;
				next_st.mode = sss_pkg::SSS_FAILSAFE;
				next_st.uv_count = sss_pkg::UV_CNT_ZERO; // see R17
				next_st.sc_timer = '0;
			end
		end else begin
			next_st.sc_timer = '0; // see R9
		end

		// Reset release after regulator good plus delay
		if (st.reset_low && st.reg_on && !below && st.mode != sss_pkg::SSS_FAILSAFE) begin
			next_st.rd_timer = st.rd_timer + 32'h1;
			if (st.rd_timer >= 32'(RESET_DELAY_CYCLES - 1)) begin
				next_st.reset_low = 1'b0; // see R7
				next_st.rd_timer = '0;
				next_st.wd_on = 1'b1;
				next_st.long_win = 1'b1;
				if (st.mode == sss_pkg::SSS_RESTART) begin
					next_st.mode = sss_pkg::SSS_NORMAL; // see R19
					next_st.fail_out = 1'b0;
				end
			end
		end

		// Wake from sleep or fail-safe by bus activity
		if (wake && (st.mode == sss_pkg::SSS_SLEEP || st.mode == sss_pkg::SSS_FAILSAFE)) begin
			next_st.mode = sss_pkg::SSS_RESTART; // see R22
			next_st.reg_on = 1'b1;
			next_st.reset_low = 1'b1;
			next_st.rd_timer = '0;
			next_st.fail_out = 1'b0;
		end

		// Supply loss: full internal reset and defaults
		if (!supply_por_ok) begin
			next_st = load_defaults(next_st); // see R8
		end else if (!st.flags[sss_pkg::ST_POR_BIT] && st.mode == sss_pkg::SSS_INIT && st.reset_low
		             && st.rd_timer == '0 && st.uv_count == sss_pkg::UV_CNT_ZERO && !st.uv_seen) begin
			next_st.flags[sss_pkg::ST_POR_BIT] = 1'b1; // see R7
			next_st.uv_seen = 1'b1;
		end

		// Read data
		case (haddr[7:0])
			sss_pkg::REG_WAKE_CONTROL_ONE:
				next_st.rdata = 32'({st.bus_wake_wd_restart_en, st.stop_wd_disable_first});
			sss_pkg::REG_WATCHDOG_CONTROL: next_st.rdata = 32'(st.stop_wd_disable_second);
			sss_pkg::REG_MODE_CONTROL:     next_st.rdata = 32'(st.mode);
			sss_pkg::REG_SUPPLY_STATUS:
				next_st.rdata = {5'h00, st.uv_count, 3'h0, st.wd_on, 1'h0, st.mode, 6'h00, st.flags};
			sss_pkg::REG_REG_CONFIG:       next_st.rdata = 32'(st.overvolt_reset_enable);
			default:                       next_st.rdata = 32'h0000_0000;
		endcase
		if (uv_event) next_st.long_win = st.long_win;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st <= load_defaults('0);
		end else begin
			st <= next_st;
		end
	end

	assign hrdata            = st.rdata;
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign reset_output_n    = ~st.reset_low;
	assign fail_outputs      = st.fail_out;
	assign main_regulator_on = st.reg_on;
	assign bus_wake_irq      = st.irq;
	assign can_rx_low        = st.rx_low;
	assign watchdog_on       = st.wd_on;
	assign wd_long_window    = st.long_win;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_second_needs_first: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R1
		$rose(st.stop_wd_disable_second) |-> $past(st.stop_wd_disable_first))
		else $error("second enable set without first");
	chk_wake_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R6
		bus_wake_irq |-> watchdog_on && can_rx_low && wd_long_window)
		else $error("bus wake did not restart watchdog");
	chk_sleep_no_uv: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R14
		$past(st.mode) == sss_pkg::SSS_SLEEP && $past(supply_por_ok) |-> !$rose(st.flags[sss_pkg::ST_UV_BIT]))
		else $error("undervoltage flag set in sleep");
	chk_uv_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R13
		$rose(st.flags[sss_pkg::ST_UV_BIT]) |-> !reset_output_n)
		else $error("undervoltage without reset");
	chk_uv_count_max: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R16
		st.uv_count < sss_pkg::UV_FAILSAFE_COUNT)
		else $error("undervoltage counter passed fail-safe count");
	chk_uv_fs_mode: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R16
		$rose(st.flags[sss_pkg::ST_UV_FS_BIT]) |-> st.mode == sss_pkg::SSS_FAILSAFE)
		else $error("fail-safe flag without fail-safe mode");
	chk_short_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R22
		$rose(st.flags[sss_pkg::ST_SC_BIT]) |-> !main_regulator_on && fail_outputs)
		else $error("short did not switch regulator off");
	chk_ov_rst_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R19
		$past(ov) && $past(st.overvolt_reset_enable) && $past(cfg) && $past(supply_por_ok)
		&& $past(st.mode) == sss_pkg::SSS_NORMAL |-> !st.overvolt_reset_enable && fail_outputs)
		else $error("overvoltage reset enable not cleared");

endmodule

// file: sim/sss_supply_model.sv
// Regulator output comparator model standing behind the supervisor
`timescale 1ns/10ps
module sss_supply_model (
	input  wire logic main_regulator_on,
	input  wire logic droop,
	output logic      main_reg_below_reset
);
	// A switched-off or drooping regulator reads below its reset threshold
	assign main_reg_below_reset = !main_regulator_on || droop;
endmodule

// file: sim/sss_supervisor_tb.sv
// Self-checking testbench of the supply supervisor
`timescale 1ns/10ps
module sss_supervisor_tb;
	localparam int RD = 20;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rdv;
	logic        hreadyout, hresp, reset_output_n, fail_outputs, main_regulator_on;
	logic        bus_wake_irq, can_rx_low, watchdog_on, wd_long_window, main_reg_below_reset;
	logic        supply_undervolt_flag = 1'b0, hs_uv = 1'b0, hs_ov = 1'b0, prewarn = 1'b0, ov = 1'b0, droop = 1'b0;
	logic        wake = 1'b0;
	logic [31:0] seed = 32'h00017E84;
	int          n_mismatch = 0, comparisons = 0, cycles = 0;

	always #2 sys_clk = ~sys_clk;

	sss_supervisor #(.RESET_DELAY_CYCLES(RD), .SC_FILTER_CYCLES(50)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .supply_por_ok(1'b1), .supply_undervolt(supply_undervolt_flag),
		.hs_supply_undervolt(hs_uv), .hs_supply_overvolt(hs_ov), .main_reg_prewarn(prewarn),
		.main_reg_below_reset(main_reg_below_reset), .main_reg_overvolt(ov), .config_select_pin(1'b1),
		.can_wake(wake), .reset_output_n(reset_output_n), .fail_outputs(fail_outputs),
		.main_regulator_on(main_regulator_on), .bus_wake_irq(bus_wake_irq), .can_rx_low(can_rx_low),
		.watchdog_on(watchdog_on), .wd_long_window(wd_long_window));

	sss_supply_model u_supply (
		.main_regulator_on(main_regulator_on), .droop(droop), .main_reg_below_reset(main_reg_below_reset));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// Single AHB-Lite transfer; read data lands in rdv
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		tick(10);
		rst_n <= 1'b1;
		tick(10);
		chk("reset held", 32'h0, {31'h0, reset_output_n});
		for (int i = 0; i < RD + 20 && reset_output_n !== 1'b1; i++) tick(1);
		chk("reset released", 32'h1, {31'h0, reset_output_n});
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("por flag", 32'h1, {31'h0, rdv[sss_pkg::ST_POR_BIT]});
		bus(1'b0, sss_pkg::REG_WAKE_CONTROL_ONE, 32'h0);
		chk("bus wake restart", 32'h1, {31'h0, rdv[1]});
		bus(1'b1, sss_pkg::REG_MODE_CONTROL, 32'h0);
		bus(1'b1, 8'h20, xs());
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rdv);
		// Supply flags: set, survive a clear while present, clear once gone
		supply_undervolt_flag <= 1'b1;
		hs_uv <= 1'b1;
		hs_ov <= 1'b1;
		prewarn <= 1'b1;
		tick(8);
		bus(1'b1, sss_pkg::REG_SUPPLY_STATUS, 32'h0000000E);
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("supply flags", 32'h0000001E, rdv & 32'h000003FE);
		chk("mode after flags", 32'h1, {29'h0, rdv[18:16]});
		{supply_undervolt_flag, hs_uv, hs_ov, prewarn} <= 4'h0;
		tick(8);
		bus(1'b1, sss_pkg::REG_SUPPLY_STATUS, 32'h0000001E);
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("flags cleared", 32'h0, rdv & 32'h0000001E);
		// Stop-mode watchdog disable sequence
		bus(1'b1, sss_pkg::REG_WAKE_CONTROL_ONE, 32'h00000003);
		bus(1'b1, sss_pkg::REG_WATCHDOG_CONTROL, 32'h00000001);
		bus(1'b0, sss_pkg::REG_WATCHDOG_CONTROL, 32'h0);
		chk("second enable", 32'h1, {31'h0, rdv[0]});
		bus(1'b1, sss_pkg::REG_WAKE_CONTROL_ONE, 32'h00000003);
		bus(1'b0, sss_pkg::REG_WAKE_CONTROL_ONE, 32'h0);
		chk("first restarted", 32'h0, {31'h0, rdv[0]});
		bus(1'b1, sss_pkg::REG_WATCHDOG_CONTROL, 32'h00000001);
		bus(1'b0, sss_pkg::REG_WATCHDOG_CONTROL, 32'h0);
		chk("out of order", 32'h0, {31'h0, rdv[0]});
		bus(1'b1, sss_pkg::REG_WAKE_CONTROL_ONE, 32'h00000003);
		bus(1'b1, sss_pkg::REG_WATCHDOG_CONTROL, 32'h00000001);
		bus(1'b1, sss_pkg::REG_MODE_CONTROL, {30'h0, sss_pkg::CMD_STOP});
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("wd off in stop", 32'h0, {31'h0, rdv[sss_pkg::ST_WD_ON_BIT]});
		bus(1'b1, sss_pkg::REG_WATCHDOG_CONTROL, 32'h00000002);
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("wd back on", 32'h1, {31'h0, rdv[sss_pkg::ST_WD_ON_BIT]});
		bus(1'b0, sss_pkg::REG_WAKE_CONTROL_ONE, 32'h0);
		chk("first cleared", 32'h0, {31'h0, rdv[0]});
		bus(1'b1, sss_pkg::REG_MODE_CONTROL, {30'h0, sss_pkg::CMD_NORMAL});
		// Overvoltage with reset enabled and pin high
		bus(1'b1, sss_pkg::REG_REG_CONFIG, 32'h00000001);
		ov <= 1'b1;
		tick(8);
		chk("fail outputs", 32'h1, {31'h0, fail_outputs});
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("ov flag", 32'h1, {31'h0, rdv[sss_pkg::ST_OV_BIT]});
		chk("ov restart", 32'h4, {29'h0, rdv[18:16]});
		tick(RD + 10);
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("ov back normal", 32'h1, {29'h0, rdv[18:16]});
		bus(1'b0, sss_pkg::REG_REG_CONFIG, 32'h0);
		chk("ov enable self clear", 32'h0, {31'h0, rdv[0]});
		ov <= 1'b0;
		// Consecutive regulator undervoltage events up to fail-safe
		for (int k = 1; k <= 4; k++) begin
			droop <= 1'b1;
			tick(8);
			chk("reset on droop", 32'h0, {31'h0, reset_output_n});
			bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
			chk("uv flag", 32'h1, {31'h0, rdv[sss_pkg::ST_UV_BIT]});
			if (k < 4) chk("uv restart", 32'h4, {29'h0, rdv[18:16]});
			droop <= 1'b0;
			tick(RD + 15);
			bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
			chk("uv count", (k < 4) ? k : 0, {29'h0, rdv[26:24]});
			chk("uv mode", (k < 4) ? 32'h1 : 32'h5, {29'h0, rdv[18:16]});
		end
		chk("uv failsafe flag", 32'h1, {31'h0, rdv[sss_pkg::ST_UV_FS_BIT]});
		// Bus wake leaves fail-safe through restart back to normal
		wake <= 1'b1;
		tick(8);
		wake <= 1'b0;
		tick(RD + 15);
		bus(1'b0, sss_pkg::REG_SUPPLY_STATUS, 32'h0);
		chk("wake from failsafe", 32'h1, {29'h0, rdv[18:16]});
		chk("reset after wake", 32'h1, {31'h0, reset_output_n});
		tally_and_finish();
	end
endmodule
